// ### rtl/ldor_pkg.sv
package ldor_pkg;
  // ------------------------------------------------------------
  // Logical device numbers
  // ------------------------------------------------------------
  localparam logic [7:0] LDOR_LDN_UART2 = 8'h05;
  localparam logic [7:0] LDOR_LDN_KBD = 8'h07;
  localparam logic [7:0] LDOR_LDN_WAKE = 8'h0a;
  localparam logic [7:0] LDOR_LDN_MIDI = 8'h0b;
  // ------------------------------------------------------------
  // Register indexes
  // ------------------------------------------------------------
  localparam logic [7:0] LDOR_IDX_LDN_SELECT = 8'h07;
  localparam logic [7:0] LDOR_IDX_MIDI_BASE_HIGH = 8'h60;
  localparam logic [7:0] LDOR_IDX_MIDI_BASE_LOW = 8'h61;
  localparam logic [7:0] LDOR_IDX_OPTION_0 = 8'hf0;
  localparam logic [7:0] LDOR_IDX_OPTION_1 = 8'hf1;
  localparam logic [7:0] LDOR_IDX_OPTION_2 = 8'hf2;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] LDOR_RST_LDN_SELECT = 8'h00;
  localparam logic [7:0] LDOR_RST_UART2_MODE = 8'h00;
  localparam logic [7:0] LDOR_RST_IR_OPTION = 8'h02;
  localparam logic [7:0] LDOR_RST_IR_TIMEOUT = 8'h03;
  localparam logic [7:0] LDOR_RST_KBD_SELECT = 8'h00;
  localparam logic [7:0] LDOR_RST_WAKE_CLOCK = 8'h00;
  localparam logic [7:0] LDOR_RST_MIDI_HIGH = 8'h03;
  localparam logic [7:0] LDOR_RST_MIDI_LOW = 8'h30;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int LDOR_UART2_MIDI_BIT = 0;
  localparam int LDOR_UART2_HIGH_SPEED_BIT = 1;
  localparam int LDOR_UART2_TX_IDLE_BIT = 5;
  localparam logic [7:0] LDOR_UART2_STORED_MASK = 8'h23;
  localparam int LDOR_IR_RX_POLARITY_BIT = 0;
  localparam int LDOR_KBD_P12_POLARITY_BIT = 7;
  localparam int LDOR_KBD_MOUSE_ISO_BIT = 6;
  localparam int LDOR_KBD_KEY_ISO_BIT = 5;
  localparam int LDOR_KBD_MOUSE_LATCH_BIT = 4;
  localparam int LDOR_KBD_KEY_LATCH_BIT = 3;
  localparam int LDOR_KBD_PORT92_BIT = 2;
  localparam logic [7:0] LDOR_KBD_STORED_MASK = 8'hfc;
  localparam int LDOR_WAKE_CLK_ABSENT_BIT = 0;
  localparam int LDOR_WAKE_KEY_OFF_BIT = 1;
  localparam logic [7:0] LDOR_WAKE_STORED_MASK = 8'h03;
  localparam logic [7:0] LDOR_MIDI_HIGH_MASK = 8'h0f;
  localparam logic [7:0] LDOR_MIDI_LOW_MASK = 8'hfe;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int LDOR_CLK_PERIOD_NS = 10;
  localparam int LDOR_BLANK_STEP_US = 100;
  localparam int LDOR_BLANK_STEP_CYCLES = (LDOR_BLANK_STEP_US * 1000) / LDOR_CLK_PERIOD_NS;
endpackage

// ### rtl/ldor_irq_sel.sv
`timescale 1ns/100ps
`default_nettype none
module ldor_irq_sel
  import ldor_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic core_irq,
  input wire logic irq_ack,
  input wire logic latch_only,
  output logic irq_out
);
  // ------------------------------------------------------------
  // Latched copy of the core interrupt
  // ------------------------------------------------------------
  logic core_irq_d;
  logic latched;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      core_irq_d <= 1'b0;
    end else begin
      core_irq_d <= core_irq;
    end
  end

  // Set on rising edge, set wins over acknowledge
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      latched <= 1'b0;
    end else if (core_irq && !core_irq_d) begin
      latched <= 1'b1;
    end else if (irq_ack) begin
      latched <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Output select
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_out <= 1'b0;
    end else if (latch_only) begin
      irq_out <= latched;
    end else begin
      irq_out <= core_irq & latched;
    end
  end
endmodule
`default_nettype wire

// ### rtl/ldor_ir_blank.sv
`timescale 1ns/100ps
`default_nettype none
module ldor_ir_blank
  import ldor_pkg::*;
#(
  parameter int STEP_CYCLES = LDOR_BLANK_STEP_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ir_activity,
  input wire logic [7:0] timeout_steps,
  output logic ir_rx_blank
);
  // ------------------------------------------------------------
  // Step timer after activity ends
  // ------------------------------------------------------------
  logic [7:0] steps_left;
  logic [31:0] cycle_count;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      steps_left <= 8'h00;
      cycle_count <= 32'h0;
    end else if (ir_activity) begin
      steps_left <= timeout_steps;
      cycle_count <= 32'h0;
    end else if (steps_left != 8'h00) begin
      if (cycle_count == 32'(STEP_CYCLES - 1)) begin
        cycle_count <= 32'h0;
        steps_left <= steps_left - 8'h01;
      end else begin
        cycle_count <= cycle_count + 32'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ir_rx_blank <= 1'b0;
    end else begin
      ir_rx_blank <= ir_activity || (steps_left != 8'h00);
    end
  end
endmodule
`default_nettype wire

// ### rtl/ldor_option_regs.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Serial port 2 mode bit 0 enables MIDI support; off after reset.
// - Mode bit 1 selects high speed; the register resets to zero.
// - Mode bit 5: transmit pin idles low when clear, floats when set.
// - Transmit idle bit is cleared only by standby power-on reset.
// - Mode bits 4:2 and 7:6 are reserved; software writes zero.
// - Infrared option register resets to 0x02; bit 0 sets receive polarity.
// - Half-duplex timeout counts 100 us steps of receiver blanking; resets to 0x03.
// - Zero blanks only during activity; each count adds one step beyond it.
// - Keyboard select bit 7 sets output port bit 2 active level.
// - Bit 6 blocks mouse lines into the keyboard core, not wake path.
// - Bit 5 blocks keyboard lines into the keyboard core, not wake path.
// - Bit 4 picks mouse interrupt: ANDed with latch, or latch only.
// - Bit 3 picks keyboard interrupt: ANDed with latch, or latch only.
// - Bit 2 enables the fast A20/reset port; register resets to zero.
// - Keyboard device indexes 0xF1 to 0xFF read as zero.
// - Wake clock bit 0 flags a missing slow clock; standby reset only.
// - Wake clock bit 1 turns specific-key wake logic and its clock off.
// - MIDI base address from two registers; defaults 0x03 and 0x30.
// - MIDI registers sit in device 0x0B and also reset on soft reset.
module ldor_option_regs
  import ldor_pkg::*;
#(
  parameter int BLANK_STEP_CYCLES = LDOR_BLANK_STEP_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic main_power_reset,
  input wire logic hard_reset,
  input wire logic soft_reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic midi_mode_en,
  output logic uart2_high_speed,
  input wire logic uart2_tx_active,
  input wire logic uart2_tx_data,
  output logic uart2_transmit_pin_out,
  output logic uart2_transmit_pin_oe,
  input wire logic ir_rx_in,
  output logic ir_rx_to_core,
  input wire logic ir_activity,
  output logic ir_rx_blank,
  input wire logic kbc_port_bit2,
  output logic kbc_cpu_reset_out,
  input wire logic kbd_clock_line,
  input wire logic kbd_data_line,
  input wire logic mouse_clock_line,
  input wire logic mouse_data_line,
  output logic kbd_clock_to_core,
  output logic kbd_data_to_core,
  output logic mouse_clock_to_core,
  output logic mouse_data_to_core,
  output logic kbd_data_to_wake,
  output logic mouse_data_to_wake,
  input wire logic kbd_core_irq,
  input wire logic mouse_core_irq,
  input wire logic kbd_irq_ack,
  input wire logic mouse_irq_ack,
  output logic kbd_irq_out,
  output logic mouse_irq_out,
  output logic addr20_gate_port_en,
  input wire logic slow_clock_input_pin,
  output logic slow_clock_absent,
  output logic specific_key_wake_off,
  output logic slow_clock_to_wake,
  output logic [11:0] midi_base_addr
);
  // ------------------------------------------------------------
  // Decode helper
  // ------------------------------------------------------------
  function automatic logic reg_hit(input logic [7:0] cur_ldn, input logic [7:0] idx,
                                   input logic [7:0] want_ldn, input logic [7:0] want_idx);
    reg_hit = (cur_ldn == want_ldn) && (idx == want_idx);
  endfunction

  logic [7:0] ldn_select;
  logic [7:0] uart2_mode_config;
  logic [7:0] infrared_option;
  logic [7:0] infrared_half_duplex_timeout;
  logic [7:0] keyboard_reset_gate_select;
  logic [7:0] wake_clock_config;
  logic [7:0] midi_base_addr_high;
  logic [7:0] midi_base_addr_low;
  logic main_defaults;
  logic hit_uart2_mode;
  logic hit_ir_option;
  logic hit_ir_timeout;
  logic hit_kbd_select;
  logic hit_wake_clock;
  logic hit_midi_high;
  logic hit_midi_low;
  logic [7:0] next_rdata;
  logic ir_blank_raw;
  logic [1:0] core_irq_vec;
  logic [1:0] irq_ack_vec;
  logic [1:0] latch_only_vec;
  logic [1:0] irq_out_vec;

  assign main_defaults = main_power_reset || hard_reset;

  always_comb begin
    hit_uart2_mode = reg_hit(ldn_select, reg_addr, LDOR_LDN_UART2, LDOR_IDX_OPTION_0);
    hit_ir_option = reg_hit(ldn_select, reg_addr, LDOR_LDN_UART2, LDOR_IDX_OPTION_1);
    hit_ir_timeout = reg_hit(ldn_select, reg_addr, LDOR_LDN_UART2, LDOR_IDX_OPTION_2);
    hit_kbd_select = reg_hit(ldn_select, reg_addr, LDOR_LDN_KBD, LDOR_IDX_OPTION_0);
    hit_wake_clock = reg_hit(ldn_select, reg_addr, LDOR_LDN_WAKE, LDOR_IDX_OPTION_0);
    hit_midi_high = reg_hit(ldn_select, reg_addr, LDOR_LDN_MIDI, LDOR_IDX_MIDI_BASE_HIGH);
    hit_midi_low = reg_hit(ldn_select, reg_addr, LDOR_LDN_MIDI, LDOR_IDX_MIDI_BASE_LOW);
  end

  // ------------------------------------------------------------
  // Logical device select
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ldn_select <= LDOR_RST_LDN_SELECT;
    end else if (main_defaults) begin
      ldn_select <= LDOR_RST_LDN_SELECT;
    end else if (reg_write && reg_addr == LDOR_IDX_LDN_SELECT) begin
      ldn_select <= reg_wdata;
    end
  end

  // ------------------------------------------------------------
  // Serial port 2 mode
  // ------------------------------------------------------------
  // Idle select is standby powered: main and hard reset leave it alone
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      uart2_mode_config <= LDOR_RST_UART2_MODE;
    end else begin
      if (reg_write && hit_uart2_mode) begin
        uart2_mode_config <= reg_wdata & LDOR_UART2_STORED_MASK;
      end
      if (main_defaults) begin
        uart2_mode_config[LDOR_UART2_MIDI_BIT] <= LDOR_RST_UART2_MODE[LDOR_UART2_MIDI_BIT];
        uart2_mode_config[LDOR_UART2_HIGH_SPEED_BIT] <=
          LDOR_RST_UART2_MODE[LDOR_UART2_HIGH_SPEED_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // Infrared option and timeout
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      infrared_option <= LDOR_RST_IR_OPTION;
      infrared_half_duplex_timeout <= LDOR_RST_IR_TIMEOUT;
    end else if (main_defaults) begin
      infrared_option <= LDOR_RST_IR_OPTION;
      infrared_half_duplex_timeout <= LDOR_RST_IR_TIMEOUT;
    end else if (reg_write && hit_ir_option) begin
      infrared_option <= reg_wdata;
    end else if (reg_write && hit_ir_timeout) begin
      infrared_half_duplex_timeout <= reg_wdata;
    end
  end

  // ------------------------------------------------------------
  // Keyboard reset and A20 select
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      keyboard_reset_gate_select <= LDOR_RST_KBD_SELECT;
    end else if (main_defaults) begin
      keyboard_reset_gate_select <= LDOR_RST_KBD_SELECT;
    end else if (reg_write && hit_kbd_select) begin
      keyboard_reset_gate_select <= reg_wdata & LDOR_KBD_STORED_MASK;
    end
  end

  // ------------------------------------------------------------
  // Wake clock configuration, standby reset only
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_clock_config <= LDOR_RST_WAKE_CLOCK;
    end else if (reg_write && hit_wake_clock) begin
      wake_clock_config <= reg_wdata & LDOR_WAKE_STORED_MASK;
    end
  end

  // ------------------------------------------------------------
  // MIDI base address
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      midi_base_addr_high <= LDOR_RST_MIDI_HIGH;
      midi_base_addr_low <= LDOR_RST_MIDI_LOW;
    end else if (main_defaults || soft_reset) begin
      midi_base_addr_high <= LDOR_RST_MIDI_HIGH;
      midi_base_addr_low <= LDOR_RST_MIDI_LOW;
    end else if (reg_write && hit_midi_high) begin
      midi_base_addr_high <= reg_wdata & LDOR_MIDI_HIGH_MASK;
    end else if (reg_write && hit_midi_low) begin
      midi_base_addr_low <= reg_wdata & LDOR_MIDI_LOW_MASK;
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    if (reg_addr == LDOR_IDX_LDN_SELECT) begin
      next_rdata = ldn_select;
    end else if (hit_uart2_mode) begin
      next_rdata = uart2_mode_config;
    end else if (hit_ir_option) begin
      next_rdata = infrared_option;
    end else if (hit_ir_timeout) begin
      next_rdata = infrared_half_duplex_timeout;
    end else if (hit_kbd_select) begin
      next_rdata = keyboard_reset_gate_select;
    end else if (hit_wake_clock) begin
      next_rdata = wake_clock_config;
    end else if (hit_midi_high) begin
      next_rdata = midi_base_addr_high;
    end else if (hit_midi_low) begin
      next_rdata = midi_base_addr_low;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // Serial port 2 controls and transmit pin
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      midi_mode_en <= 1'b0;
      uart2_high_speed <= 1'b0;
      uart2_transmit_pin_out <= 1'b0;
      uart2_transmit_pin_oe <= 1'b1;
    end else begin
      midi_mode_en <= uart2_mode_config[LDOR_UART2_MIDI_BIT];
      uart2_high_speed <= uart2_mode_config[LDOR_UART2_HIGH_SPEED_BIT];
      if (uart2_tx_active) begin
        uart2_transmit_pin_out <= uart2_tx_data;
        uart2_transmit_pin_oe <= 1'b1;
      end else begin
        uart2_transmit_pin_out <= 1'b0;
        uart2_transmit_pin_oe <= !uart2_mode_config[LDOR_UART2_TX_IDLE_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // Infrared receive polarity and blanking
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ir_rx_to_core <= 1'b0;
      ir_rx_blank <= 1'b0;
    end else begin
      ir_rx_to_core <= ir_rx_in ^ infrared_option[LDOR_IR_RX_POLARITY_BIT];
      ir_rx_blank <= ir_blank_raw;
    end
  end

  ldor_ir_blank #(
    .STEP_CYCLES(BLANK_STEP_CYCLES)
  ) u_ir_blank (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .ir_activity(ir_activity),
    .timeout_steps(infrared_half_duplex_timeout),
    .ir_rx_blank(ir_blank_raw)
  );

  // ------------------------------------------------------------
  // Keyboard controller signal conditioning
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      kbc_cpu_reset_out <= 1'b1;
      addr20_gate_port_en <= 1'b0;
      kbd_clock_to_core <= 1'b1;
      kbd_data_to_core <= 1'b1;
      mouse_clock_to_core <= 1'b1;
      mouse_data_to_core <= 1'b1;
      kbd_data_to_wake <= 1'b1;
      mouse_data_to_wake <= 1'b1;
    end else begin
      kbc_cpu_reset_out <=
        keyboard_reset_gate_select[LDOR_KBD_P12_POLARITY_BIT] ? kbc_port_bit2 : !kbc_port_bit2;
      addr20_gate_port_en <= keyboard_reset_gate_select[LDOR_KBD_PORT92_BIT];
      kbd_clock_to_core <= kbd_clock_line | keyboard_reset_gate_select[LDOR_KBD_KEY_ISO_BIT];
      kbd_data_to_core <= kbd_data_line | keyboard_reset_gate_select[LDOR_KBD_KEY_ISO_BIT];
      mouse_clock_to_core <=
        mouse_clock_line | keyboard_reset_gate_select[LDOR_KBD_MOUSE_ISO_BIT];
      mouse_data_to_core <=
        mouse_data_line | keyboard_reset_gate_select[LDOR_KBD_MOUSE_ISO_BIT];
      kbd_data_to_wake <= kbd_data_line;
      mouse_data_to_wake <= mouse_data_line;
    end
  end

  // ------------------------------------------------------------
  // Keyboard and mouse interrupt shaping
  // ------------------------------------------------------------
  assign core_irq_vec = {mouse_core_irq, kbd_core_irq};
  assign irq_ack_vec = {mouse_irq_ack, kbd_irq_ack};
  assign latch_only_vec = {keyboard_reset_gate_select[LDOR_KBD_MOUSE_LATCH_BIT],
                           keyboard_reset_gate_select[LDOR_KBD_KEY_LATCH_BIT]};

  generate
    for (genvar i = 0; i < 2; i++) begin : g_irq
      ldor_irq_sel u_irq_sel (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .core_irq(core_irq_vec[i]),
        .irq_ack(irq_ack_vec[i]),
        .latch_only(latch_only_vec[i]),
        .irq_out(irq_out_vec[i])
      );
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      kbd_irq_out <= 1'b0;
      mouse_irq_out <= 1'b0;
    end else begin
      kbd_irq_out <= irq_out_vec[0];
      mouse_irq_out <= irq_out_vec[1];
    end
  end

  // ------------------------------------------------------------
  // Wake clock and MIDI address outputs
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      slow_clock_absent <= 1'b0;
      specific_key_wake_off <= 1'b0;
      slow_clock_to_wake <= 1'b0;
      midi_base_addr <= 12'h000;
    end else begin
      slow_clock_absent <= wake_clock_config[LDOR_WAKE_CLK_ABSENT_BIT];
      specific_key_wake_off <= wake_clock_config[LDOR_WAKE_KEY_OFF_BIT];
      slow_clock_to_wake <= slow_clock_input_pin && !wake_clock_config[LDOR_WAKE_KEY_OFF_BIT]
                            && !wake_clock_config[LDOR_WAKE_CLK_ABSENT_BIT];
      midi_base_addr <= {midi_base_addr_high[3:0], midi_base_addr_low[7:1], 1'b0};
    end
  end
endmodule
`default_nettype wire

// ### sim/ldor_option_regs_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module ldor_option_regs_chk (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic soft_reset,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic kbd_data_line,
  input wire logic kbd_data_to_wake,
  input wire logic kbd_data_to_core,
  input wire logic [11:0] midi_base_addr,
  input wire logic ir_activity,
  input wire logic ir_rx_blank,
  input wire logic kbd_core_irq,
  input wire logic kbd_irq_out,
  input wire logic uart2_tx_active,
  input wire logic uart2_transmit_pin_oe,
  input wire logic uart2_transmit_pin_out
);
  // ----------------------------------
  // Port checks
  // ----------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  a_rdata_idle_zero: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  a_wake_path_copy: assert property ($past(reset_n) |-> kbd_data_to_wake == $past(kbd_data_line))
    else $error("wake path not a copy of data line");
  a_core_low_cause: assert property ($past(reset_n) && !kbd_data_to_core |-> !$past(kbd_data_line))
    else $error("core data low without line low");
  a_midi_soft_default: assert property ($past(soft_reset, 2) |-> midi_base_addr == 12'h330)
    else $error("base address not default after soft reset");
  a_blank_on_activity: assert property (ir_activity |-> ##[1:2] ir_rx_blank)
    else $error("no blanking during activity");
  a_irq_out_rise: assert property ($rose(kbd_core_irq) |-> ##[2:4] kbd_irq_out)
    else $error("keyboard irq out late");
  a_tx_float_idle: assert property (!uart2_transmit_pin_oe |-> !$past(uart2_tx_active))
    else $error("pin floated while sending");
  a_tx_idle_low: assert property ($past(reset_n) && !$past(uart2_tx_active) |-> !uart2_transmit_pin_out)
    else $error("idle pin not low");
endmodule
bind ldor_option_regs ldor_option_regs_chk u_chk (.*);
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // ----------------------------------
  // Bench
  // ----------------------------------
  logic ref_clk, reset_n, main_power_reset, hard_reset, soft_reset, reg_write, reg_read;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic midi_mode_en, uart2_high_speed, uart2_tx_active, uart2_tx_data, uart2_transmit_pin_out;
  logic uart2_transmit_pin_oe, ir_rx_in, ir_rx_to_core, ir_activity, ir_rx_blank, kbc_port_bit2;
  logic kbc_cpu_reset_out, kbd_clock_line, kbd_data_line, mouse_clock_line, mouse_data_line;
  logic kbd_clock_to_core, kbd_data_to_core, mouse_clock_to_core, mouse_data_to_core;
  logic kbd_data_to_wake, mouse_data_to_wake, kbd_core_irq, mouse_core_irq, kbd_irq_ack;
  logic mouse_irq_ack, kbd_irq_out, mouse_irq_out, addr20_gate_port_en, slow_clock_input_pin;
  logic slow_clock_absent, specific_key_wake_off, slow_clock_to_wake;
  logic [11:0] midi_base_addr;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  ldor_option_regs #(.BLANK_STEP_CYCLES(4)) u_dut (.*);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 chk({4'h0, reg_rdata}, {4'h0, e});
  endtask
  task automatic rl(input logic [7:0] n, input logic [7:0] a, input logic [7:0] e);
    wr(8'h07, n);
    rd(a, e);
  endtask
  task automatic t_defaults();
    rl(8'h05, 8'hf0, 8'h00);
    rl(8'h05, 8'hf1, 8'h02);
    rl(8'h05, 8'hf2, 8'h03);
    rl(8'h07, 8'hf0, 8'h00);
    rl(8'h07, 8'hf5, 8'h00);
    rl(8'h0a, 8'hf0, 8'h00);
    rl(8'h0b, 8'h60, 8'h03);
    rd(8'h61, 8'h30);
    rd(8'hf0, 8'h00);
    chk(midi_base_addr, 12'h330);
  endtask
  task automatic t_uart2();
    wr(8'h07, 8'h05);
    wr(8'hf0, 8'hff);
    rd(8'hf0, 8'h23);
    chk({9'h0, midi_mode_en, uart2_high_speed, uart2_transmit_pin_oe}, 12'h6);
    uart2_tx_active <= 1'b1;
    uart2_tx_data <= 1'b1;
    cy(2);
    #1 chk({10'h0, uart2_transmit_pin_oe, uart2_transmit_pin_out}, 12'h3);
    uart2_tx_active <= 1'b0;
    hard_reset <= 1'b1;
    cy(1);
    hard_reset <= 1'b0;
    rl(8'h05, 8'hf0, 8'h20);
    wr(8'hf0, 8'h00);
    cy(2);
    #1 chk({10'h0, uart2_transmit_pin_oe, uart2_transmit_pin_out}, 12'h2);
  endtask
  task automatic t_kbd();
    kbc_port_bit2 <= 1'b1;
    kbd_data_line <= 1'b0;
    mouse_data_line <= 1'b0;
    kbd_clock_line <= 1'b0;
    mouse_clock_line <= 1'b0;
    wr(8'h07, 8'h07);
    wr(8'hf0, 8'hff);
    rd(8'hf0, 8'hfc);
    cy(2);
    #1 chk({4'h0, kbc_cpu_reset_out, addr20_gate_port_en, kbd_data_to_core, mouse_data_to_core,
      kbd_clock_to_core, mouse_clock_to_core, kbd_data_to_wake, mouse_data_to_wake},
      12'h0fc);
    wr(8'hf0, 8'h00);
    cy(2);
    #1 chk({4'h0, kbc_cpu_reset_out, addr20_gate_port_en, kbd_data_to_core, mouse_data_to_core,
      kbd_clock_to_core, mouse_clock_to_core, kbd_data_to_wake, mouse_data_to_wake},
      12'h000);
    kbd_core_irq <= 1'b1;
    cy(4);
    #1 chk({11'h0, kbd_irq_out}, 12'h1);
    kbd_core_irq <= 1'b0;
    cy(4);
    #1 chk({11'h0, kbd_irq_out}, 12'h0);
    kbd_irq_ack <= 1'b1;
    cy(1);
    kbd_irq_ack <= 1'b0;
    wr(8'hf0, 8'h18);
    kbd_core_irq <= 1'b1;
    mouse_core_irq <= 1'b1;
    cy(2);
    kbd_core_irq <= 1'b0;
    mouse_core_irq <= 1'b0;
    cy(4);
    #1 chk({10'h0, kbd_irq_out, mouse_irq_out}, 12'h3);
    kbd_irq_ack <= 1'b1;
    cy(1);
    kbd_irq_ack <= 1'b0;
    cy(3);
    #1 chk({10'h0, kbd_irq_out, mouse_irq_out}, 12'h1);
  endtask
  task automatic t_ir();
    wr(8'h07, 8'h05);
    wr(8'hf1, 8'h01);
    ir_rx_in <= 1'b1;
    wr(8'hf2, 8'h02);
    #1 chk({11'h0, ir_rx_to_core}, 12'h0);
    ir_activity <= 1'b1;
    cy(3);
    ir_activity <= 1'b0;
    cy(6);
    #1 chk({11'h0, ir_rx_blank}, 12'h1);
    cy(6);
    #1 chk({11'h0, ir_rx_blank}, 12'h0);
    wr(8'hf2, 8'h00);
    ir_activity <= 1'b1;
    cy(3);
    ir_activity <= 1'b0;
    cy(4);
    #1 chk({11'h0, ir_rx_blank}, 12'h0);
  endtask
  task automatic t_wake_midi();
    wr(8'h07, 8'h0a);
    wr(8'hf0, 8'h03);
    main_power_reset <= 1'b1;
    cy(1);
    main_power_reset <= 1'b0;
    cy(2);
    #1 chk({9'h0, slow_clock_absent, specific_key_wake_off, slow_clock_to_wake}, 12'h6);
    rl(8'h0a, 8'hf0, 8'h03);
    wr(8'hf0, 8'h00);
    cy(2);
    #1 chk({9'h0, slow_clock_absent, specific_key_wake_off, slow_clock_to_wake}, 12'h1);
    wr(8'h07, 8'h0b);
    wr(8'h60, 8'hff);
    wr(8'h61, 8'hff);
    rd(8'h60, 8'h0f);
    rd(8'h61, 8'hfe);
    cy(2);
    #1 chk(midi_base_addr, 12'hffe);
    soft_reset <= 1'b1;
    cy(1);
    soft_reset <= 1'b0;
    cy(3);
    #1 chk(midi_base_addr, 12'h330);
  endtask
  initial begin
    {reset_n, main_power_reset, hard_reset, soft_reset, reg_write, reg_read, reg_addr} = '0;
    {reg_wdata, uart2_tx_active, uart2_tx_data, ir_rx_in, ir_activity, kbc_port_bit2} = '0;
    {kbd_core_irq, mouse_core_irq, kbd_irq_ack, mouse_irq_ack} = '0;
    {kbd_clock_line, kbd_data_line, mouse_clock_line, mouse_data_line} = 4'hf;
    slow_clock_input_pin = 1'b1;
    cy(20);
    reset_n <= 1'b1;
    t_defaults();
    t_uart2();
    t_kbd();
    t_ir();
    t_wake_midi();
    report_and_stop();
  end
endmodule
`default_nettype wire
